// ==== rtl/cmd_dev_map.svh ====
`ifndef CMD_DEV_MAP_SVH
`define CMD_DEV_MAP_SVH

// ----------------------------------------------------------------------
// channel command codes
// ----------------------------------------------------------------------
`define QUEUE_LOCATION_CMD      8'h13
`define CLASSIC_FLAG_SETUP_CMD  8'h43
`define CHANGE_FLAG_SETUP_CMD   8'h53
`define TWO_STAGE_FLAG_SETUP_CMD 8'h73
`define FEATURE_READ_CMD        8'h12
`define FEATURE_WRITE_CMD       8'h11
`define CONFIG_WRITE_CMD        8'h22
`define CONFIG_READ_CMD_CODE    8'h02
`define STATUS_WRITE_CMD        8'h31
`define QUEUE_INFO_QUERY_CMD    8'h32
`define REVISION_SELECT_CMD     8'h83
`define STATUS_READ_CMD         8'h72

// ----------------------------------------------------------------------
// revisions
// ----------------------------------------------------------------------
`define REV_MAX                 16'h0002
`define REV_STATUS_READ         16'h0002
`define REV_LEGACY              16'h0000

// ----------------------------------------------------------------------
// payload sizes in bytes
// ----------------------------------------------------------------------
`define LEN_REVISION            16'h0004
`define LEN_QUEUE_QUERY         16'h0002
`define LEN_QUEUE_INFO_OUT      16'h0002
`define LEN_QUEUE_LOC           16'h0020
`define LEN_QUEUE_LOC_LEGACY    16'h0010
`define LEN_STATUS              16'h0001
`define LEN_FEATURE_BLOCK       16'h0005
`define LEN_FEATURE_WORD        16'h0004
`define LEN_FLAG_ADDR           16'h0008
`define LEN_TWO_STAGE           16'h0019
`define LEN_CONFIG_SPACE        16'h0040
`define LEN_NONE                16'h0000

`endif

// ==== rtl/cmd_dev_pkg.sv ====
package cmd_dev_pkg;

	// ------------------------------------------------------------------
	// command sequencer states, one-hot
	// ------------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,	// waiting for a command
		ST_RECV = 5'h02,	// collecting payload bytes
		ST_EXEC = 5'h04,	// acting on the collected block
		ST_SEND = 5'h08,	// returning answer bytes
		ST_DONE = 5'h10		// ending status for one cycle
	} seq_state_t;

endpackage

// ==== rtl/payload_collector.sv ====
`timescale 1ns/1ps
`include "cmd_dev_map.svh"

// ----------------------------------------------------------------------
// big-endian payload gatherer: newest byte lands in the low bits
// ----------------------------------------------------------------------
module payload_collector (
	// clock and reset
	input  wire logic         ref_clk_i,
	input  wire logic         rst_i,
	// byte stream
	input  wire logic         clear_i,
	input  wire logic         take_i,
	input  wire logic [7:0]   byte_i,
	// gathered block
	output logic      [255:0] block_o,
	output logic      [15:0]  count_o
);

	// shift register, 32 bytes covers the largest block
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || clear_i) begin
			block_o <= '0;
		end else if (take_i) begin
			block_o <= {block_o[247:0], byte_i};
		end
	end

	// byte count; config writes can exceed the register depth
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || clear_i) begin
			count_o <= 16'h0000;
		end else if (take_i) begin
			count_o <= count_o + 16'h0001;
		end
	end

endmodule

// ==== rtl/channel_cmd_dev_setup.sv ====
`timescale 1ns/1ps
`include "cmd_dev_map.svh"

// Rules for driver and device; this block covers the device side
// R1: driver tries highest revision, steps down on reject
// R2: driver selects revision before transport commands
// R3: driver never reselects revision after success
// R4: reject of revision select: abandon or legacy
// R5: non-transitional rejects commands before revision select
// R6: transitional assumes legacy revision 0, rejects rest
// R7: queue query returns max buffers for index
// R8: queue location block parsed, reserved word ignored
// R9: legacy or revision 0 uses legacy block
// R10: refused status write keeps status, rejects
// R11: driver keeps old status after reject
// R12: status read returns status from revision 2
// R13: driver reads status only from revision 2
// R14: feature block five bytes, little-endian word, index
// R15: feature read offers bits, write accepts bits
// R16: config commands move whole configuration space
// R17: classic setup rejected after two-stage setup
// R18: two-stage setup rejected after classic setup
// R19: classic setup carries 64-bit indicator address
// R20: change indicators classic, 64-bit address given
// R21: two-stage block 25 bytes incl. subclass
// R22: one flag per queue, MSB-first bit numbering
// R23: unimplemented commands get command reject
// R24: commands outside selected revision get reject

module channel_cmd_dev_setup
	import cmd_dev_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	// device straps and state from the device core
	input  wire logic        transitional_i,
	input  wire logic        sch_enable_i,
	input  wire logic        status_accept_i,
	input  wire logic [15:0] qmax_i,
	input  wire logic [31:0] feat_offer_i,
	input  wire logic [7:0]  cfg_rdata_i,
	input  wire logic [15:0] flag_queue_i,
	// command port
	input  wire logic        cmd_valid_i,
	input  wire logic [7:0]  cmd_code_i,
	output logic             cmd_ready_o,
	output logic             done_o,
	output logic             reject_o,
	// payload in
	input  wire logic        in_valid_i,
	input  wire logic [7:0]  in_byte_i,
	output logic             in_ready_o,
	// answer out
	output logic             out_valid_o,
	output logic [7:0]       out_byte_o,
	input  wire logic        out_ready_i,
	// revision and status
	output logic             rev_set_o,
	output logic             legacy_o,
	output logic [15:0]      rev_o,
	output logic [7:0]       dev_status_o,
	output logic [7:0]       status_candidate_o,
	// queue query and location
	output logic [15:0]      qmax_index_o,
	output logic             vq_set_o,
	output logic             vq_legacy_o,
	output logic [15:0]      vq_index_o,
	output logic [15:0]      vq_num_o,
	output logic [63:0]      vq_desc_o,
	output logic [63:0]      vq_avail_o,
	output logic [63:0]      vq_used_o,
	output logic [31:0]      vq_align_o,
	// features
	output logic [7:0]       feat_index_o,
	output logic             feat_wr_o,
	output logic [31:0]      feat_wr_word_o,
	output logic [7:0]       feat_wr_index_o,
	// configuration space
	output logic [15:0]      cfg_rd_addr_o,
	output logic             cfg_wr_o,
	output logic [15:0]      cfg_wr_addr_o,
	output logic [7:0]       cfg_wdata_o,
	// indicators
	output logic             classic_flag_valid_o,
	output logic [63:0]      classic_flag_addr_o,
	output logic             change_flag_valid_o,
	output logic [63:0]      change_flag_addr_o,
	output logic             two_stage_valid_o,
	output logic [63:0]      two_stage_summary_addr_o,
	output logic [63:0]      two_stage_area_addr_o,
	output logic [63:0]      first_flag_position_o,
	output logic [7:0]       two_stage_isc_o,
	output logic [63:0]      flag_byte_addr_o,
	output logic [7:0]       flag_bit_mask_o
);

	// ------------------------------------------------------------------
	// functions
	// ------------------------------------------------------------------

	// byte holding a queue's flag; bit 0 is the msb of byte 0
	function automatic logic [63:0] flag_byte(input logic [63:0] area,
	                                           input logic [63:0] first,
	                                           input logic [15:0] queue);
		logic [63:0] pos;
		pos = first + {48'h0000_0000_0000, queue};
		flag_byte = area + {3'h0, pos[63:3]};
	endfunction

	// mask within that byte, msb-first numbering
	function automatic logic [7:0] flag_mask(input logic [63:0] first,
	                                          input logic [15:0] queue);
		logic [63:0] pos;
		pos = first + {48'h0000_0000_0000, queue};
		flag_mask = 8'h80 >> pos[2:0];
	endfunction

	// ------------------------------------------------------------------
	// state and storage
	// ------------------------------------------------------------------
	seq_state_t   state;            // sequencer state
	logic [7:0]   cmd_q;            // command being served
	logic         rej;              // current command is refused
	logic [15:0]  in_need;          // payload bytes expected
	logic [15:0]  out_need;         // answer bytes owed
	logic [15:0]  send_cnt;         // answer bytes still to go
	logic [31:0]  send_word;        // short answers, msb byte first
	logic         sch_en_q;         // enable level, previous cycle
	logic [255:0] blk;              // gathered payload
	logic [15:0]  got;              // payload bytes taken

	// ------------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------------
	// in idle the incoming code is decoded, afterwards the stored one
	wire [7:0] code      = (state == ST_IDLE) ? cmd_code_i : cmd_q;
	wire is_rev          = (code == `REVISION_SELECT_CMD);
	wire is_qinfo        = (code == `QUEUE_INFO_QUERY_CMD);
	wire is_setvq        = (code == `QUEUE_LOCATION_CMD);
	wire is_wst          = (code == `STATUS_WRITE_CMD);
	wire is_rst          = (code == `STATUS_READ_CMD);
	wire is_rfeat        = (code == `FEATURE_READ_CMD);
	wire is_wfeat        = (code == `FEATURE_WRITE_CMD);
	wire is_rconf        = (code == `CONFIG_READ_CMD_CODE);
	wire is_wconf        = (code == `CONFIG_WRITE_CMD);
	wire is_ind          = (code == `CLASSIC_FLAG_SETUP_CMD);
	wire is_cind         = (code == `CHANGE_FLAG_SETUP_CMD);
	wire is_aind         = (code == `TWO_STAGE_FLAG_SETUP_CMD);
	wire transport       = is_qinfo | is_setvq | is_wst | is_rst | is_rfeat | is_wfeat
	                     | is_rconf | is_wconf | is_ind | is_cind | is_aind;
	wire known           = transport | is_rev;

	// a transitional device falls back to legacy on an early command
	wire need_legacy     = transport & ~rev_set_o & transitional_i;        // [R6]
	wire eff_set         = rev_set_o | need_legacy;
	wire eff_legacy      = legacy_o | need_legacy | (rev_o == `REV_LEGACY);
	wire rev_lt2         = need_legacy | (rev_o < `REV_STATUS_READ);

	// refusal that is known from the code alone
	wire rej_unknown     = ~known;                                         // [R23]
	wire rej_early       = transport & ~eff_set;                           // [R5]
	wire rej_reselect    = is_rev & (rev_set_o | legacy_o);                // [R6]
	wire rej_rev_level   = is_rst & rev_lt2;                               // [R24]
	wire rej_classic     = is_ind & two_stage_valid_o;                     // [R17]
	wire rej_two_stage   = is_aind & classic_flag_valid_o;                 // [R18]
	wire reject_now      = rej_unknown | rej_early | rej_reselect | rej_rev_level
	                     | rej_classic | rej_two_stage;

	// payload size in, depends on the queue block format
	wire [15:0] in_len   = is_rev   ? `LEN_REVISION :
	                       is_qinfo ? `LEN_QUEUE_QUERY :
	                       is_setvq ? (eff_legacy ? `LEN_QUEUE_LOC_LEGACY : `LEN_QUEUE_LOC) :  // [R9]
	                       is_wst   ? `LEN_STATUS :
	                       (is_rfeat | is_wfeat) ? `LEN_FEATURE_BLOCK :                   // [R14]
	                       is_wconf ? `LEN_CONFIG_SPACE :                                 // [R16]
	                       (is_ind | is_cind) ? `LEN_FLAG_ADDR :
	                       is_aind  ? `LEN_TWO_STAGE : `LEN_NONE;                          // [R21]

	// answer size out
	wire [15:0] out_len  = is_qinfo ? `LEN_QUEUE_INFO_OUT :
	                       is_rst   ? `LEN_STATUS :
	                       is_rfeat ? `LEN_FEATURE_WORD :
	                       is_rconf ? `LEN_CONFIG_SPACE : `LEN_NONE;                       // [R16]

	// ------------------------------------------------------------------
	// field extraction from the gathered block
	// ------------------------------------------------------------------
	wire [15:0] rev_val  = blk[31:16];
	wire [15:0] rev_len  = blk[15:0];
	// length field must be zero for every supported revision
	wire rev_ok          = (rev_len == 16'h0000) && (rev_val <= `REV_MAX)
	                     && ((rev_val != `REV_LEGACY) || transitional_i);
	// little-endian feature word, then the window index
	wire [31:0] feat_le  = {blk[15:8], blk[23:16], blk[31:24], blk[39:32]};  // [R14]
	wire exec_fail       = (is_rev & ~rev_ok) | (is_wst & ~status_accept_i);

	// ------------------------------------------------------------------
	// handshakes
	// ------------------------------------------------------------------
	wire take            = in_valid_i & in_ready_o;
	wire out_free        = ~out_valid_o | out_ready_i;
	wire start           = (state == ST_IDLE) & cmd_valid_i;

	assign cmd_ready_o   = (state == ST_IDLE);
	assign in_ready_o    = (state == ST_RECV) & (got < in_need);
	assign done_o        = (state == ST_DONE);
	assign reject_o      = (state == ST_DONE) & rej;
	assign status_candidate_o = blk[7:0];
	assign qmax_index_o  = blk[15:0];                                     // [R7]
	assign feat_index_o  = blk[7:0];                                      // [R15]
	assign cfg_rd_addr_o = `LEN_CONFIG_SPACE - send_cnt;

	// ------------------------------------------------------------------
	// payload gatherer
	// ------------------------------------------------------------------
	payload_collector u_collect (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.clear_i   (start),
		.take_i    (take),
		.byte_i    (in_byte_i),
		.block_o   (blk),
		.count_o   (got)
	);

	// ------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			rej   <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					rej <= 1'b0;
					if (cmd_valid_i) begin
						if (reject_now) begin
							rej   <= 1'b1;
							state <= ST_DONE;
						end else if (in_len == `LEN_NONE) begin
							state <= ST_EXEC;
						end else begin
							state <= ST_RECV;
						end
					end
				end
				ST_RECV: begin
					if (got == in_need) begin
						state <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					// failed actions leave stored state alone
					rej <= exec_fail;                                     // [R10]
					if (exec_fail || out_need == `LEN_NONE) begin
						state <= ST_DONE;
					end else begin
						state <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (send_cnt == 16'h0000 && !out_valid_o) begin
						state <= ST_DONE;
					end
				end
				ST_DONE: begin
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// command latch and sizes
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			cmd_q    <= 8'h00;
			in_need  <= 16'h0000;
			out_need <= 16'h0000;
		end else if (start) begin
			cmd_q    <= cmd_code_i;
			in_need  <= in_len;
			out_need <= out_len;
		end
	end

	// ------------------------------------------------------------------
	// revision tracking; unset again on each subchannel enable
	// ------------------------------------------------------------------
	wire sch_rise = sch_enable_i & ~sch_en_q;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			sch_en_q  <= 1'b0;
			rev_set_o <= 1'b0;
			legacy_o  <= 1'b0;
			rev_o     <= 16'h0000;
		end else begin
			sch_en_q <= sch_enable_i;
			if (sch_rise) begin
				rev_set_o <= 1'b0;
				legacy_o  <= 1'b0;
				rev_o     <= 16'h0000;
			end
			if (start && need_legacy) begin
				// legacy driver assumed, revision 0 fixed
				rev_set_o <= 1'b1;                                    // [R6]
				legacy_o  <= 1'b1;
				rev_o     <= `REV_LEGACY;
			end else if (state == ST_EXEC && is_rev && rev_ok) begin
				rev_set_o <= 1'b1;
				rev_o     <= rev_val;
			end
		end
	end

	// ------------------------------------------------------------------
	// status; only an accepted write changes it
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			dev_status_o <= 8'h00;
		end else if (state == ST_EXEC && is_wst && status_accept_i) begin
			dev_status_o <= blk[7:0];                                  // [R10]
		end
	end

	// ------------------------------------------------------------------
	// queue location; reserved word never looked at
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			vq_set_o    <= 1'b0;
			vq_legacy_o <= 1'b0;
			vq_index_o  <= 16'h0000;
			vq_num_o    <= 16'h0000;
			vq_desc_o   <= '0;
			vq_avail_o  <= '0;
			vq_used_o   <= '0;
			vq_align_o  <= 32'h0000_0000;
		end else begin
			vq_set_o <= (state == ST_EXEC) & is_setvq;
			if (state == ST_EXEC && is_setvq && eff_legacy) begin
				vq_legacy_o <= 1'b1;                                  // [R9]
				vq_desc_o   <= blk[127:64];
				vq_align_o  <= blk[63:32];
				vq_index_o  <= blk[31:16];
				vq_num_o    <= blk[15:0];
				vq_avail_o  <= '0;
				vq_used_o   <= '0;
			end else if (state == ST_EXEC && is_setvq) begin
				vq_legacy_o <= 1'b0;                                  // [R8]
				vq_desc_o   <= blk[255:192];
				vq_index_o  <= blk[159:144];
				vq_num_o    <= blk[143:128];
				vq_avail_o  <= blk[127:64];
				vq_used_o   <= blk[63:0];
				vq_align_o  <= 32'h0000_0000;
			end
		end
	end

	// ------------------------------------------------------------------
	// feature and configuration writes
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			feat_wr_o       <= 1'b0;
			feat_wr_word_o  <= 32'h0000_0000;
			feat_wr_index_o <= 8'h00;
			cfg_wr_o        <= 1'b0;
			cfg_wr_addr_o   <= 16'h0000;
			cfg_wdata_o     <= 8'h00;
		end else begin
			feat_wr_o <= (state == ST_EXEC) & is_wfeat;
			if (state == ST_EXEC && is_wfeat) begin
				feat_wr_word_o  <= feat_le;                           // [R15]
				feat_wr_index_o <= blk[7:0];
			end
			// config bytes go straight through, one per accepted byte
			cfg_wr_o <= take & is_wconf;                              // [R16]
			if (take && is_wconf) begin
				cfg_wr_addr_o <= got;
				cfg_wdata_o   <= in_byte_i;
			end
		end
	end

	// ------------------------------------------------------------------
	// indicator setup; modes exclusive until subchannel re-enable
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			classic_flag_valid_o     <= 1'b0;
			classic_flag_addr_o      <= '0;
			change_flag_valid_o      <= 1'b0;
			change_flag_addr_o       <= '0;
			two_stage_valid_o        <= 1'b0;
			two_stage_summary_addr_o <= '0;
			two_stage_area_addr_o    <= '0;
			first_flag_position_o    <= '0;
			two_stage_isc_o          <= 8'h00;
		end else begin
			if (sch_rise) begin
				classic_flag_valid_o <= 1'b0;
				change_flag_valid_o  <= 1'b0;
				two_stage_valid_o    <= 1'b0;
			end
			if (state == ST_EXEC) begin
				if (is_ind) begin
					classic_flag_valid_o <= 1'b1;                         // [R19]
					classic_flag_addr_o  <= blk[63:0];
				end
				if (is_cind) begin
					change_flag_valid_o <= 1'b1;                          // [R20]
					change_flag_addr_o  <= blk[63:0];
				end
				if (is_aind) begin
					two_stage_valid_o        <= 1'b1;                     // [R21]
					two_stage_summary_addr_o <= blk[199:136];
					two_stage_area_addr_o    <= blk[135:72];
					first_flag_position_o    <= blk[71:8];
					two_stage_isc_o          <= blk[7:0];
				end
			end
		end
	end

	// per-queue flag location for the notifier, registered
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			flag_byte_addr_o <= '0;
			flag_bit_mask_o  <= 8'h00;
		end else begin
			flag_byte_addr_o <= flag_byte(two_stage_area_addr_o, first_flag_position_o,
			                              flag_queue_i);             // [R22]
			flag_bit_mask_o  <= flag_mask(first_flag_position_o, flag_queue_i);  // [R22]
		end
	end

	// ------------------------------------------------------------------
	// answer path
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			send_cnt    <= 16'h0000;
			send_word   <= 32'h0000_0000;
			out_valid_o <= 1'b0;
			out_byte_o  <= 8'h00;
		end else if (state == ST_EXEC) begin
			send_cnt <= exec_fail ? 16'h0000 : out_need;
			if (is_qinfo) begin
				send_word <= {qmax_i, 16'h0000};                      // [R7]
			end else if (is_rst) begin
				send_word <= {dev_status_o, 24'h00_0000};             // [R12]
			end else begin
				// offered word goes out little-endian
				send_word <= {feat_offer_i[7:0], feat_offer_i[15:8],
				              feat_offer_i[23:16], feat_offer_i[31:24]};  // [R15]
			end
		end else if (state == ST_SEND && out_free && send_cnt != 16'h0000) begin
			out_valid_o <= 1'b1;
			send_cnt    <= send_cnt - 16'h0001;
			if (is_rconf) begin
				out_byte_o <= cfg_rdata_i;                            // [R16]
			end else begin
				out_byte_o <= send_word[31:24];
				send_word  <= {send_word[23:0], 8'h00};
			end
		end else if (out_ready_i) begin
			out_valid_o <= 1'b0;
		end
	end

endmodule

// ==== test/cmd_dev_monitor.sv ====
`timescale 1ns/1ps
// ----------------------------------------------
// command port checker
// ----------------------------------------------
module cmd_dev_mon (
	input wire logic        ref_clk_i, rst_i, transitional_i, cmd_valid_i, cmd_ready_o, done_o, reject_o,
	input wire logic        rev_set_o, legacy_o, classic_flag_valid_o, two_stage_valid_o,
	input wire logic [7:0]  cmd_code_i, dev_status_o, flag_bit_mask_o,
	input wire logic [15:0] rev_o, flag_queue_i,
	input wire logic [63:0] first_flag_position_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	wire take = cmd_valid_i && cmd_ready_o; // command taken at this edge
	AST_REJ_DONE: assert property (reject_o |-> done_o) else $error("reject without done");
	AST_DONE_ONE: assert property (done_o |=> !done_o && cmd_ready_o) else $error("done not one pulse");
	AST_NO_REV: assert property (take && cmd_code_i == 8'h13 && !rev_set_o && !legacy_o && !transitional_i
		|=> done_o && reject_o) else $error("queue command before revision not refused");
	AST_REV_ONCE: assert property (take && cmd_code_i == 8'h83 && (rev_set_o || legacy_o)
		|=> done_o && reject_o) else $error("second revision select not refused");
	AST_RD_LOW: assert property (take && cmd_code_i == 8'h72 && rev_o < 16'h0002
		|=> done_o && reject_o) else $error("status read below revision 2 not refused");
	AST_KEEP: assert property (done_o && reject_o |-> $stable(dev_status_o)) else $error("status moved");
	AST_EXCL: assert property (!(classic_flag_valid_o && two_stage_valid_o)) else $error("both flag kinds");
	AST_MASK: assert property (!$past(rst_i) |-> flag_bit_mask_o ==
		8'h80 >> (($past(first_flag_position_o) + $past(flag_queue_i)) & 64'h7)) else $error("flag mask wrong");
endmodule
bind channel_cmd_dev_setup cmd_dev_mon u_mon (.ref_clk_i, .rst_i, .transitional_i, .cmd_valid_i, .cmd_ready_o,
	.done_o, .reject_o, .rev_set_o, .legacy_o, .classic_flag_valid_o, .two_stage_valid_o, .cmd_code_i,
	.dev_status_o, .flag_bit_mask_o, .rev_o, .flag_queue_i, .first_flag_position_o);

// ==== test/guest_drv_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------
// guest driver: sends payload, takes answers
// ----------------------------------------------
module guest_drv_model (
	input  wire logic       ref_clk_i, in_ready_i, out_valid_i,
	input  wire logic [7:0] out_byte_i,
	output logic            in_valid_o = 1'b0,
	output logic [7:0]      in_byte_o = 8'h00,
	output logic            out_ready_o = 1'b0
);
	logic [7:0] tx[$]; // payload left, big-endian order
	logic [7:0] rx[$]; // answer bytes
	// idle data toggles so a stale byte never looks fresh
	always @(posedge ref_clk_i) begin
		if (in_valid_o && in_ready_i)
			void'(tx.pop_front());
		if (out_valid_i && out_ready_o)
			rx.push_back(out_byte_i);
		in_valid_o <= tx.size() != 0;
		in_byte_o <= tx.size() != 0 ? tx[0] : ~in_byte_o;
		out_ready_o <= ~out_ready_o; // slow and prompt in turn
	end
endmodule

// ==== test/channel_cmd_dev_setup_tb.sv ====
`timescale 1ns/1ps
module channel_cmd_dev_setup_tb;
	logic        ref_clk_i, rst_i = 1'b1, transitional_i = 1'b0, sch_enable_i = 1'b1;
	logic        status_accept_i = 1'b0, cmd_valid_i = 1'b0;
	logic [7:0]  cmd_code_i = 8'h00;
	logic [15:0] flag_queue_i = 16'h0000;
	wire logic   cmd_ready_o, done_o, reject_o, in_valid_i, in_ready_o, out_valid_o, out_ready_i, legacy_o;
	wire logic [7:0]  in_byte_i, out_byte_o, dev_status_o, feat_index_o;
	wire logic [63:0] classic_flag_addr_o;
	int          fails = 0, checks_done = 0;
	channel_cmd_dev_setup u_dut (.ref_clk_i, .rst_i, .transitional_i, .sch_enable_i, .status_accept_i,
		.qmax_i(16'h0100), .feat_offer_i(32'h4433_2211), .cfg_rdata_i(8'h5a), .flag_queue_i, .cmd_valid_i,
		.cmd_code_i, .cmd_ready_o, .done_o, .reject_o, .in_valid_i, .in_byte_i, .in_ready_o, .out_valid_o,
		.out_byte_o, .out_ready_i, .rev_set_o(), .legacy_o, .rev_o(), .dev_status_o, .status_candidate_o(),
		.qmax_index_o(), .vq_set_o(), .vq_legacy_o(), .vq_index_o(), .vq_num_o(), .vq_desc_o(), .vq_avail_o(),
		.vq_used_o(), .vq_align_o(), .feat_index_o, .feat_wr_o(), .feat_wr_word_o(), .feat_wr_index_o(),
		.cfg_rd_addr_o(), .cfg_wr_o(), .cfg_wr_addr_o(), .cfg_wdata_o(), .classic_flag_valid_o(),
		.classic_flag_addr_o, .change_flag_valid_o(), .change_flag_addr_o(), .two_stage_valid_o(),
		.two_stage_summary_addr_o(), .two_stage_area_addr_o(), .first_flag_position_o(), .two_stage_isc_o(),
		.flag_byte_addr_o(), .flag_bit_mask_o());
	guest_drv_model u_drv (.ref_clk_i, .in_ready_i(in_ready_o), .out_valid_i(out_valid_o),
		.out_byte_i(out_byte_o), .in_valid_o(in_valid_i), .in_byte_o(in_byte_i), .out_ready_o(out_ready_i));
	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	// one command: hold it until taken, then wait bounded for done
	task automatic run(input logic [7:0] code, input logic rej);
		int n = 0;
		@(posedge ref_clk_i) cmd_valid_i <= 1'b1;
		cmd_code_i <= code;
		do @(posedge ref_clk_i); while (cmd_ready_o !== 1'b1);
		cmd_valid_i <= 1'b0;
		do @(posedge ref_clk_i); while (done_o !== 1'b1 && ++n < 300);
		chk("reject", {done_o, reject_o}, {1'b1, rej});
	endtask
	task automatic final_report;
		if (fails == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) flag_queue_i <= flag_queue_i + 16'h0001;
	initial begin
		repeat (5000) @(posedge ref_clk_i);
		fails++;
		final_report();
	end
	initial begin
		repeat (8) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		run(8'h13, 1'b1);
		run(8'h33, 1'b1);
		u_drv.tx = '{8'h00, 8'h03, 8'h00, 8'h00};
		run(8'h83, 1'b1);
		u_drv.tx = '{8'h00, 8'h02, 8'h00, 8'h00};
		run(8'h83, 1'b0);
		run(8'h83, 1'b1);
		u_drv.tx = '{8'h0f};
		run(8'h31, 1'b1);
		chk("status", dev_status_o, 8'h00);
		status_accept_i <= 1'b1;
		u_drv.tx = '{8'h0f};
		run(8'h31, 1'b0);
		u_drv.rx.delete();
		run(8'h72, 1'b0);
		chk("status read", u_drv.rx[0], 8'h0f);
		u_drv.tx = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
		u_drv.rx.delete();
		run(8'h12, 1'b0);
		chk("feature window", feat_index_o, 8'h01);
		chk("feature word", {u_drv.rx[3], u_drv.rx[2], u_drv.rx[1], u_drv.rx[0]}, 32'h4433_2211);
		u_drv.tx = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h12, 8'h38};
		run(8'h43, 1'b0);
		chk("classic address", classic_flag_addr_o, 64'h0000_0000_0000_1238);
		run(8'h73, 1'b1);
		u_drv.tx = '{8'h00, 8'h03};
		u_drv.rx.delete();
		run(8'h32, 1'b0);
		run(8'h02, 1'b0);
		chk("queue max", {u_drv.rx[0], u_drv.rx[1]}, 16'h0100);
		chk("config read", {u_drv.rx.size(), u_drv.rx[65]}, {32'd66, 8'h5a});
		@(posedge ref_clk_i) sch_enable_i <= 1'b0;
		transitional_i <= 1'b1;
		@(posedge ref_clk_i) sch_enable_i <= 1'b1;
		u_drv.tx = '{8'h05};
		run(8'h31, 1'b0);
		chk("legacy", legacy_o, 1'b1);
		run(8'h83, 1'b1);
		run(8'h72, 1'b1);
		final_report();
	end
endmodule
